/* hw/mgmt_serial_pkg.sv */
package mgmt_serial_pkg;

  // ****************************************
  // frame layout
  // ****************************************
  localparam logic [4:0] INT_PHY_ADDR  = 5'h18;  // address of the on-chip register set
  localparam int         PRE_ONES      = 32;     // ones before the start field
  localparam int         HDR_BITS      = 12;     // opcode, phy address, register address
  localparam int         DATA_BITS     = 16;
  localparam int         SKIP_BITS     = 18;     // turnaround plus data of a foreign frame
  localparam logic [1:0] OP_READ       = 2'h2;
  localparam logic [1:0] OP_WRITE      = 2'h1;
  localparam int         REG_AW        = 5;
  localparam logic [15:0] REG_RESET    = 16'h0000;

  // ****************************************
  // types
  // ****************************************
  // software control bits of the serial control register
  typedef struct packed {
    logic serial_clock_bit;
    logic serial_data_bit;
    logic drive_direction_bit;
  } ctrl_bits_t;

  // one driver of the management pins
  typedef struct packed {
    logic mdc;
    logic mdio;
    logic mdio_oe;
  } pin_drive_t;

  typedef enum logic [2:0] {
    ST_PRE   = 3'b000,
    ST_START = 3'b001,
    ST_HDR   = 3'b010,
    ST_TA    = 3'b011,
    ST_RDATA = 3'b100,
    ST_WTA   = 3'b101,
    ST_WDATA = 3'b110,
    ST_SKIP  = 3'b111
  } frame_st_t;

endpackage

/* hw/phy_reg_file.sv */
`timescale 1ns/1ps
module phy_reg_file #(
  parameter int AW = 5,
  parameter int DW = 16
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata_ff
);

  logic [DW-1:0] mem_ff [2**AW];
  logic [DW-1:0] nxt_rdata;

  // ****************************************
  // storage, one word per entry
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < 2**AW; gi++) begin : g_word
      logic [DW-1:0] nxt_word;
      always_comb begin
        nxt_word = mem_ff[gi];
        if (we && (waddr == AW'(gi))) begin
          nxt_word = wdata;
        end
      end
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          mem_ff[gi] <= mgmt_serial_pkg::REG_RESET;
        end else begin
          mem_ff[gi] <= nxt_word;
        end
      end
    end
  endgenerate

  // ****************************************
  // registered read port
  // ****************************************
  always_comb begin
    nxt_rdata = mem_ff[raddr];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= mgmt_serial_pkg::REG_RESET;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

endmodule

/* hw/mgmt_serial_port.sv */
`timescale 1ns/1ps
module mgmt_serial_port (
  input  wire logic                        mclk,
  input  wire logic                        rstn,
  input  wire logic                        link_clk,
  input  wire mgmt_serial_pkg::ctrl_bits_t sw_ctrl,
  input  wire logic                        mdio_i,
  output mgmt_serial_pkg::pin_drive_t      host_pins_ff,
  output logic                             serial_data_in_ff,
  output logic                             phy_mdio_o_ff,
  output logic                             phy_mdio_oe_ff
);

  // ****************************************
  // software side: pins follow control bits
  // ****************************************
  mgmt_serial_pkg::pin_drive_t nxt_pins;
  logic                        sync1_ff;
  logic                        nxt_sync1;
  logic                        nxt_data_in;

  // copy of the control bits, no reordering
  always_comb begin
    nxt_pins.mdc     = sw_ctrl.serial_clock_bit;
    nxt_pins.mdio    = sw_ctrl.serial_data_bit;
    nxt_pins.mdio_oe = sw_ctrl.drive_direction_bit;
    nxt_sync1        = mdio_i;
    nxt_data_in      = sync1_ff;                      // released line reads pull-up
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      host_pins_ff      <= '0;
      sync1_ff          <= 1'b1;
      serial_data_in_ff <= 1'b1;
    end else begin
      host_pins_ff      <= nxt_pins;
      sync1_ff          <= nxt_sync1;
      serial_data_in_ff <= nxt_data_in;
    end
  end

  // ****************************************
  // link side reset release
  // ****************************************
  logic lrst1_ff;
  logic lrst_n_ff;

  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      lrst1_ff  <= 1'b0;
      lrst_n_ff <= 1'b0;
    end else begin
      lrst1_ff  <= 1'b1;
      lrst_n_ff <= lrst1_ff;
    end
  end

  // ****************************************
  // link side: on-chip phy frame decoder
  // ****************************************
  mgmt_serial_pkg::frame_st_t st_ff;
  mgmt_serial_pkg::frame_st_t nxt_st;
  logic [5:0]                 ones_ff;
  logic [5:0]                 nxt_ones;
  logic [4:0]                 cnt_ff;
  logic [4:0]                 nxt_cnt;
  logic [11:0]                hdr_ff;
  logic [11:0]                nxt_hdr;
  logic [15:0]                shift_ff;
  logic [15:0]                nxt_shift;
  logic                       nxt_mdio_o;
  logic                       nxt_mdio_oe;
  logic                       mem_we;
  logic [15:0]                mem_rdata;
  logic [11:0]                hdr_full;
  logic                       addr_hit;

  // header including the bit sampled at this edge
  assign hdr_full = {hdr_ff[10:0], mdio_i};
  assign addr_hit = (hdr_full[9:5] == mgmt_serial_pkg::INT_PHY_ADDR);

  // bits are sampled on the rising link clock edge
  always_comb begin
    nxt_st      = st_ff;
    nxt_ones    = ones_ff;
    nxt_cnt     = cnt_ff;
    nxt_hdr     = hdr_ff;
    nxt_shift   = shift_ff;
    nxt_mdio_o  = phy_mdio_o_ff;
    nxt_mdio_oe = phy_mdio_oe_ff;
    mem_we      = 1'b0;
    case (st_ff)
      mgmt_serial_pkg::ST_PRE: begin
        // count ones, saturating at the preamble length
        if (mdio_i) begin
          if (ones_ff < 6'(mgmt_serial_pkg::PRE_ONES)) begin
            nxt_ones = ones_ff + 6'h01;
          end
        end else begin
          nxt_ones = 6'h00;
          if (ones_ff == 6'(mgmt_serial_pkg::PRE_ONES)) begin
            nxt_st = mgmt_serial_pkg::ST_START;             // first start bit
          end
        end
      end
      mgmt_serial_pkg::ST_START: begin
        nxt_cnt = 5'h00;
        nxt_st  = mdio_i ? mgmt_serial_pkg::ST_HDR : mgmt_serial_pkg::ST_PRE;
      end
      mgmt_serial_pkg::ST_HDR: begin
        nxt_hdr = hdr_full;                                   // one bit per pulse
        nxt_cnt = cnt_ff + 5'h01;
        if (cnt_ff == 5'(mgmt_serial_pkg::HDR_BITS - 1)) begin
          nxt_cnt = 5'h00;
          if (!addr_hit) begin
            nxt_st = mgmt_serial_pkg::ST_SKIP;              // leave line to other phy
          end else if (hdr_full[11:10] == mgmt_serial_pkg::OP_READ) begin
            nxt_st = mgmt_serial_pkg::ST_TA;
          end else if (hdr_full[11:10] == mgmt_serial_pkg::OP_WRITE) begin
            nxt_st = mgmt_serial_pkg::ST_WTA;
          end else begin
            nxt_st = mgmt_serial_pkg::ST_SKIP;
          end
        end
      end
      mgmt_serial_pkg::ST_TA: begin
        // host has released; answer with zero
        nxt_mdio_o  = 1'b0;
        nxt_mdio_oe = 1'b1;
        nxt_shift   = mem_rdata;
        nxt_cnt     = 5'h00;
        nxt_st      = mgmt_serial_pkg::ST_RDATA;
      end
      mgmt_serial_pkg::ST_RDATA: begin
        nxt_cnt = cnt_ff + 5'h01;
        if (cnt_ff == 5'(mgmt_serial_pkg::DATA_BITS)) begin
          nxt_mdio_oe = 1'b0;                               // closing release cycle
          nxt_st      = mgmt_serial_pkg::ST_PRE;
        end else begin
          nxt_mdio_o = shift_ff[15];                        // msb first
          nxt_shift  = {shift_ff[14:0], 1'b0};
        end
      end
      mgmt_serial_pkg::ST_WTA: begin
        nxt_cnt = cnt_ff + 5'h01;
        if (cnt_ff == 5'h01) begin
          nxt_cnt = 5'h00;
          nxt_st  = mgmt_serial_pkg::ST_WDATA;             // turnaround 10 passed
        end
      end
      mgmt_serial_pkg::ST_WDATA: begin
        nxt_shift = {shift_ff[14:0], mdio_i};               // msb first
        nxt_cnt   = cnt_ff + 5'h01;
        if (cnt_ff == 5'(mgmt_serial_pkg::DATA_BITS - 1)) begin
          mem_we = 1'b1;
          nxt_st = mgmt_serial_pkg::ST_PRE;
        end
      end
      mgmt_serial_pkg::ST_SKIP: begin
        nxt_cnt = cnt_ff + 5'h01;
        if (cnt_ff == 5'(mgmt_serial_pkg::SKIP_BITS - 1)) begin
          nxt_st = mgmt_serial_pkg::ST_PRE;
        end
      end
      default: begin
        nxt_st      = mgmt_serial_pkg::ST_PRE;
        nxt_mdio_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge link_clk or negedge lrst_n_ff) begin
    if (!lrst_n_ff) begin
      st_ff          <= mgmt_serial_pkg::ST_PRE;
      ones_ff        <= 6'h00;
      cnt_ff         <= 5'h00;
      hdr_ff         <= 12'h000;
      shift_ff       <= 16'h0000;
      phy_mdio_o_ff  <= 1'b1;
      phy_mdio_oe_ff <= 1'b0;
    end else begin
      st_ff          <= nxt_st;
      ones_ff        <= nxt_ones;
      cnt_ff         <= nxt_cnt;
      hdr_ff         <= nxt_hdr;
      shift_ff       <= nxt_shift;
      phy_mdio_o_ff  <= nxt_mdio_o;
      phy_mdio_oe_ff <= nxt_mdio_oe;
    end
  end

  // ****************************************
  // on-chip register set
  // ****************************************
  phy_reg_file #(
    .AW (mgmt_serial_pkg::REG_AW),
    .DW (mgmt_serial_pkg::DATA_BITS)
  ) u_regs (
    .clk      (link_clk),
    .rst_n    (lrst_n_ff),
    .we       (mem_we),
    .waddr    (hdr_ff[4:0]),
    .wdata    ({shift_ff[14:0], mdio_i}),
    .raddr    (hdr_full[4:0]),
    .rdata_ff (mem_rdata)
  );

endmodule

/* sim/mgmt_serial_checker.sv */
`timescale 1ns/1ps
// ****************************************
// port checks
// ****************************************
module mgmt_serial_checker (
  input wire logic                        mclk,
  input wire logic                        rstn,
  input wire logic                        link_clk,
  input wire mgmt_serial_pkg::ctrl_bits_t sw_ctrl,
  input wire logic                        mdio_i,
  input wire mgmt_serial_pkg::pin_drive_t host_pins_ff,
  input wire logic                        serial_data_in_ff,
  input wire logic                        phy_mdio_o_ff,
  input wire logic                        phy_mdio_oe_ff
);
  // software side
  a_pins_follow: assert property (@(posedge mclk) disable iff (!rstn)
    $past(rstn) |-> host_pins_ff == $past(sw_ctrl)) else $error("pins not a copy");
  a_dir_release: assert property (@(posedge mclk) disable iff (!rstn)
    $past(rstn) && $fell(sw_ctrl.drive_direction_bit) |=> !host_pins_ff.mdio_oe)
    else $error("line still driven");
  a_clock_copy: assert property (@(posedge mclk) disable iff (!rstn)
    $past(rstn) && $rose(sw_ctrl.serial_clock_bit) |=> $rose(host_pins_ff.mdc))
    else $error("clock edge lost");
  a_data_in_delay: assert property (@(posedge mclk) disable iff (!rstn)
    $past(rstn, 2) && $past(rstn) |-> serial_data_in_ff == $past(mdio_i, 2))
    else $error("data in late");
  // link side
  a_ack_zero: assert property (@(posedge link_clk) disable iff (!rstn)
    $rose(phy_mdio_oe_ff) |-> !phy_mdio_o_ff) else $error("ack not zero");
  a_oe_span: assert property (@(posedge link_clk) disable iff (!rstn)
    $rose(phy_mdio_oe_ff) |-> ##16 phy_mdio_oe_ff ##1 !phy_mdio_oe_ff)
    else $error("drive span wrong");
  a_read_addr: assert property (@(posedge link_clk) disable iff (!rstn)
    $rose(phy_mdio_oe_ff) |-> $past(mdio_i, 11) && $past(mdio_i, 10) && !$past(mdio_i, 9)
    && !$past(mdio_i, 8) && !$past(mdio_i, 7)) else $error("answered wrong address");
  a_start_op: assert property (@(posedge link_clk) disable iff (!rstn)
    $rose(phy_mdio_oe_ff) |-> !$past(mdio_i, 15) && $past(mdio_i, 14) && $past(mdio_i, 13)
    && !$past(mdio_i, 12)) else $error("answered without read");
endmodule

/* sim/ext_phy_model.sv */
`timescale 1ns/1ps
// ****************************************
// off-chip phy
// ****************************************
module ext_phy_model #(
  parameter logic [4:0]  ADDR = 5'h03,
  parameter logic [15:0] DATA = 16'h5a3c
) (
  input  wire logic mdc,
  input  wire logic mdio,
  output logic      oe,
  output logic      dout
);
  logic [45:0] sh_ff = '0;
  logic [45:0] nx;
  int          cnt = 0;
  assign nx = {sh_ff[44:0], mdio};
  initial oe = 1'b0;
  initial dout = 1'b1;
  // answer reads after 32 ones, ack zero then data msb first
  always @(posedge mdc) begin
    sh_ff <= nx;
    if (cnt > 0) begin
      cnt <= cnt - 1;
      oe <= (cnt > 1);
      dout <= (cnt == 18) ? 1'b0 : DATA[(cnt > 1) ? cnt - 2 : 0];
    end else if (nx[45:5] == {32'hffff_ffff, 4'h6, ADDR}) begin
      cnt <= 18;
    end
  end
endmodule

/* sim/mgmt_serial_port_tb_top.sv */
`timescale 1ns/1ps
// ****************************************
// bench
// ****************************************
module mgmt_serial_port_tb_top;
  logic                        mclk = 0, rstn = 0, link_clk = 0, lk_en = 1;
  logic                        din, phy_o, phy_oe, ext_o, ext_oe, mdio_w, ack;
  mgmt_serial_pkg::ctrl_bits_t sw_ctrl = '0;
  mgmt_serial_pkg::pin_drive_t pins;
  int                          miscompares = 0, n_compared = 0, seed = 69796, cyc = 0;
  logic [15:0]                 mem [32];
  logic [15:0]                 v;
  always #12.5 mclk = ~mclk;
  // link clock runs through reset and within frames except the stretched write turnaround bit, stops low otherwise
  initial begin
    #7;
    forever #32 if (lk_en || link_clk) link_clk = ~link_clk;
  end
  // wire with pull-up
  assign mdio_w = pins.mdio_oe ? pins.mdio : phy_oe ? phy_o : ext_oe ? ext_o : 1'b1;
  mgmt_serial_port dut (.mclk(mclk), .rstn(rstn), .link_clk(link_clk), .sw_ctrl(sw_ctrl),
    .mdio_i(mdio_w), .host_pins_ff(pins), .serial_data_in_ff(din),
    .phy_mdio_o_ff(phy_o), .phy_mdio_oe_ff(phy_oe));
  ext_phy_model u_ext (.mdc(link_clk), .mdio(mdio_w), .oe(ext_oe), .dout(ext_o));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (exp !== got) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  // one host bit, placed after the clock rises
  task automatic bit_out(input logic b, input logic dir);
    @(posedge link_clk);
    @(posedge mclk);
    sw_ctrl <= '{1'b1, b, dir};
  endtask
  task automatic hdr(input int ones, input logic [1:0] op, input logic [4:0] pa, ra);
    logic [13:0] h;
    h = {2'b01, op, pa, ra};
    lk_en = 1;
    repeat (ones) bit_out(1'b1, 1'b1);
    for (int i = 13; i >= 0; i--) bit_out(h[i], 1'b1);
  endtask
  task automatic fin;
    repeat (3) @(posedge link_clk);
    lk_en = 0;
    repeat (4) @(posedge mclk);
  endtask
  task automatic wr(input logic [4:0] pa, ra, input logic [15:0] d);
    hdr(34, mgmt_serial_pkg::OP_WRITE, pa, ra);
    bit_out(1'b1, 1'b1);
    bit_out(1'b0, 1'b1);
    lk_en = 0; // stretched bit time, clock parked low
    repeat (20) @(posedge mclk);
    lk_en = 1;
    for (int i = 15; i >= 0; i--) bit_out(d[i], 1'b1);
    bit_out(1'b1, 1'b0);
    fin();
  endtask
  task automatic rd(input int n, input logic [1:0] op, input logic [4:0] pa, ra,
                    input logic ea, input logic [15:0] ed);
    logic [15:0] d;
    hdr(n, op, pa, ra);
    bit_out(1'b1, 1'b0);
    repeat (2) @(posedge link_clk);
    chk("ack", 16'(ea), 16'(din));
    for (int i = 15; i >= 0; i--) begin
      @(posedge link_clk);
      d[i] = din;
    end
    chk("rdata", ed, d);
    bit_out(1'b1, 1'b0); // closing release cycle
    fin();
  endtask
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      test_done();
    end
  end
  initial begin
    logic [4:0]                  ras [5];
    mgmt_serial_pkg::ctrl_bits_t q;
    for (int i = 0; i < 32; i++) mem[i] = mgmt_serial_pkg::REG_RESET;
    repeat (4) @(posedge mclk);
    rstn <= 1;
    // let the link side leave reset, then park its clock
    repeat (3) @(posedge link_clk);
    lk_en = 0;
    for (int i = 0; i < 40; i++) begin
      @(posedge mclk);
      sw_ctrl <= 3'($random(seed));
      #1;
      if (i > 0) chk("pins", 16'(q), 16'(pins));
      q = sw_ctrl;
    end
    @(posedge mclk);
    sw_ctrl <= '0;
    repeat (4) @(posedge mclk);
    chk("idle", 16'h0001, 16'(din));
    ras = '{5'h00, 5'h1f, 5'($random(seed)), 5'($random(seed)), 5'($random(seed))};
    for (int k = 0; k < 4; k++) begin
      v = 16'($random(seed));
      wr(mgmt_serial_pkg::INT_PHY_ADDR, ras[k], v);
      mem[ras[k]] = v;
    end
    for (int k = 0; k < 5; k++)
      rd(34, mgmt_serial_pkg::OP_READ, mgmt_serial_pkg::INT_PHY_ADDR, ras[k], 0, mem[ras[k]]);
    rd(34, mgmt_serial_pkg::OP_READ, 5'h03, 5'h02, 0, 16'h5a3c);
    rd(34, mgmt_serial_pkg::OP_READ, 5'h0a, 5'h00, 1, 16'hffff);
    rd(34, 2'h0, mgmt_serial_pkg::INT_PHY_ADDR, ras[0], 1, 16'hffff);
    rd(20, mgmt_serial_pkg::OP_READ, mgmt_serial_pkg::INT_PHY_ADDR, ras[1], 1, 16'hffff);
    rd(34, mgmt_serial_pkg::OP_READ, mgmt_serial_pkg::INT_PHY_ADDR, ras[1], 0, mem[ras[1]]);
    test_done();
  end
endmodule
bind mgmt_serial_port mgmt_serial_checker u_chk (.mclk(mclk), .rstn(rstn), .link_clk(link_clk),
  .sw_ctrl(sw_ctrl), .mdio_i(mdio_i), .host_pins_ff(host_pins_ff),
  .serial_data_in_ff(serial_data_in_ff), .phy_mdio_o_ff(phy_mdio_o_ff),
  .phy_mdio_oe_ff(phy_mdio_oe_ff));
